// >>> verilog/pfc_pkg.sv
`default_nettype none
package pfc_pkg;
   // Register indices on the documented register port
   localparam logic [3:0] REG_SETPOINT_IDX   = 4'h6;
   localparam logic [3:0] REG_SERIAL_SEL_IDX = 4'hf;
   localparam int         SERIAL_SEL_SP_BIT  = 1;
   localparam logic [15:0] REG_SETPOINT_RESET   = 16'h0000;
   localparam logic [15:0] REG_SERIAL_SEL_RESET = 16'h0000;

   // Input function codes
   localparam logic [4:0] AIN_FUNC_FEEDBACK = 5'h0b;
   localparam logic [4:0] AIN_FUNC_SETPOINT = 5'h0c;
   localparam logic [4:0] AIN_FUNC_DIFF_FB  = 5'h16;
   localparam logic [2:0] PULSE_FUNC_FEEDBACK = 3'h1;
   localparam logic [2:0] PULSE_FUNC_SETPOINT = 3'h2;

   // Mode selector values
   localparam logic [2:0] MODE_OFF       = 3'h0;
   localparam logic [2:0] MODE_DIRECT_IN = 3'h1;
   localparam logic [2:0] MODE_DIRECT_FB = 3'h2;
   localparam logic [2:0] MODE_TRIM_DIFF = 3'h3;
   localparam logic [2:0] MODE_TRIM_FB   = 3'h4;

   // Tuning ranges and reset values (gain 0.01, I-time 0.1 s, D-time 0.01 s)
   localparam logic [11:0] GAIN_MAX    = 12'h9c4;
   localparam logic [11:0] GAIN_RESET  = 12'h064;
   localparam logic [11:0] ITIME_MAX   = 12'he10;
   localparam logic [11:0] ITIME_RESET = 12'h00a;
   localparam logic [9:0]  DTIME_MAX   = 10'h3e8;
   localparam logic [9:0]  DTIME_RESET = 10'h000;
   localparam int          GAIN_SCALE  = 100;

   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_TIME_NS  = 1_000_000;
   localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;
   localparam int ITIME_UNIT_NS = 100_000_000;
   localparam int ITIME_TICKS   = ITIME_UNIT_NS / TICK_TIME_NS;
   localparam int DTIME_UNIT_NS = 10_000_000;
   localparam int DTIME_TICKS   = DTIME_UNIT_NS / TICK_TIME_NS;

   // Arithmetic width of the controller datapath
   localparam int CALC_W = 48;

   typedef struct packed {
      logic [4:0] ain1_func;
      logic [4:0] ain2_func;
      logic [2:0] pulse_func;
      logic       param_sp_en;
   } pfc_route_t;

   typedef struct packed {
      logic [2:0]  mode;
      logic [11:0] gain;
      logic [11:0] itime;
      logic [9:0]  dtime;
   } pfc_tune_t;

   typedef struct packed {
      logic signed [15:0] ain1;
      logic signed [15:0] ain2;
      logic signed [15:0] pulse;
      logic signed [15:0] param_sp;
   } pfc_inputs_t;
endpackage
`default_nettype wire

// >>> verilog/pfc_divider.sv
`timescale 1ns/10ps
`default_nettype none
module pfc_divider #(
   parameter int W = 48
) (
   input  wire logic         mclk_in,
   input  wire logic         arst_n_in,
   input  wire logic         start_in,
   input  wire logic [W-1:0] dividend_in,
   input  wire logic [W-1:0] divisor_in,
   output logic      [W-1:0] quotient_out,
   output logic              done_out
);
   localparam int CW = $clog2(W + 1);

   logic [W-1:0]  rem_q;
   logic [W-1:0]  quo_q;
   logic [W-1:0]  div_q;
   logic [CW-1:0] cnt_q;
   logic          busy_q;
   logic [W:0]    trial;

   generate
      if (W < 8) begin : g_chk
         $error("pfc_divider width too small");
      end
   endgenerate

   // Shift in next dividend bit and try subtracting
   assign trial = {rem_q, quo_q[W-1]} - {1'b0, div_q};

   // Restoring division, one quotient bit per clock
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rem_q  <= '0;
         quo_q  <= '0;
         div_q  <= '0;
         cnt_q  <= '0;
         busy_q <= 1'b0;
      end else if (start_in) begin
         rem_q  <= '0;
         quo_q  <= dividend_in;
         div_q  <= divisor_in;
         cnt_q  <= CW'(W);
         busy_q <= 1'b1;
      end else if (busy_q) begin
         if (!trial[W]) begin
            rem_q <= trial[W-1:0];
            quo_q <= {quo_q[W-2:0], 1'b1};
         end else begin
            rem_q <= {rem_q[W-2:0], quo_q[W-1]};
            quo_q <= {quo_q[W-2:0], 1'b0};
         end
         cnt_q <= cnt_q - 1'b1;
         if (cnt_q == CW'(1)) begin
            busy_q <= 1'b0;
         end
      end
   end

   // Done pulse one cycle after the last step
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         done_out <= 1'b0;
      end else begin
         done_out <= busy_q && (cnt_q == CW'(1)) && !start_in;
      end
   end

   assign quotient_out = quo_q;
endmodule
`default_nettype wire

// >>> verilog/pfc_source_select.sv
`timescale 1ns/10ps
`default_nettype none
module pfc_source_select
   import pfc_pkg::*;
(
   input  wire pfc_pkg::pfc_route_t  route_in,
   input  wire pfc_pkg::pfc_inputs_t inputs_in,
   input  wire logic                 serial_sp_en_in,
   input  wire logic signed [15:0]   serial_sp_in,
   output logic signed [15:0]        setpoint_out,
   output logic signed [15:0]        feedback_out,
   output logic signed [15:0]        feedback_two_out,
   output logic                      diff_fb_en_out,
   output logic                      conflict_out
);
   logic [4:0] sp_hit;
   logic [2:0] fb_hit;
   logic [1:0] df_hit;

   // True when more than one bit of a group is set
   function automatic logic multi(input logic [4:0] v);
      logic [2:0] n;
      n = 3'h0;
      for (int i = 0; i < 5; i++) begin
         n = n + {2'b00, v[i]};
      end
      return n > 3'h1;
   endfunction

   // Which inputs claim each role
   always_comb begin
      sp_hit = {route_in.ain1_func == AIN_FUNC_SETPOINT,
                route_in.ain2_func == AIN_FUNC_SETPOINT,
                serial_sp_en_in,
                route_in.pulse_func == PULSE_FUNC_SETPOINT,
                route_in.param_sp_en};
      fb_hit = {route_in.ain1_func == AIN_FUNC_FEEDBACK,
                route_in.ain2_func == AIN_FUNC_FEEDBACK,
                route_in.pulse_func == PULSE_FUNC_FEEDBACK};
      df_hit = {route_in.ain1_func == AIN_FUNC_DIFF_FB,
                route_in.ain2_func == AIN_FUNC_DIFF_FB};
   end

   // Duplicate allocation of any role
   assign conflict_out = multi(sp_hit) || multi({2'b00, fb_hit}) || multi({3'b000, df_hit});

   // Setpoint mux, first claimant wins
   always_comb begin
      if (sp_hit[4])      setpoint_out = inputs_in.ain1;
      else if (sp_hit[3]) setpoint_out = inputs_in.ain2;
      else if (sp_hit[2]) setpoint_out = serial_sp_in;
      else if (sp_hit[1]) setpoint_out = inputs_in.pulse;
      else if (sp_hit[0]) setpoint_out = inputs_in.param_sp;
      else                setpoint_out = 16'sh0000;
   end

   // Feedback muxes
   always_comb begin
      if (fb_hit[2])      feedback_out = inputs_in.ain1;
      else if (fb_hit[1]) feedback_out = inputs_in.ain2;
      else if (fb_hit[0]) feedback_out = inputs_in.pulse;
      else                feedback_out = 16'sh0000;
      if (df_hit[1])      feedback_two_out = inputs_in.ain1;
      else if (df_hit[0]) feedback_two_out = inputs_in.ain2;
      else                feedback_two_out = 16'sh0000;
   end

   assign diff_fb_en_out = |df_hit;
endmodule
`default_nettype wire

// >>> verilog/pfc_controller.sv
`timescale 1ns/10ps
`default_nettype none
module pfc_controller
   import pfc_pkg::*;
#(
   parameter int TICK_CYCLES_P = TICK_CYCLES
) (
   input  wire logic                 mclk_in,
   input  wire logic                 arst_n_in,
   input  wire logic                 reg_wr_in,
   input  wire logic [3:0]           reg_addr_in,
   input  wire logic [15:0]          reg_wdata_in,
   output logic      [15:0]          reg_rdata_out,
   input  wire logic                 tune_load_in,
   input  wire pfc_pkg::pfc_tune_t   tune_in,
   input  wire pfc_pkg::pfc_route_t  route_in,
   input  wire pfc_pkg::pfc_inputs_t inputs_in,
   input  wire logic signed [15:0]   freq_ref_in,
   output logic signed [15:0]        freq_cmd_out,
   output logic signed [15:0]        feedback_monitor_out,
   output logic                      setting_conflict_alarm_out,
   output logic                      pid_active_out,
   output pfc_pkg::pfc_tune_t        tune_out
);
   import pfc_pkg::*;

   localparam int CW = CALC_W;
   localparam int TW = $clog2(TICK_CYCLES_P);

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_DIV  = 3'b010,
      ST_OUT  = 3'b100
   } pfc_state_t;

   pfc_state_t              state_q;
   pfc_tune_t               tune_q;
   logic [15:0]             sp_word_q;
   logic [15:0]             sel_word_q;
   logic [TW-1:0]           tick_cnt_q;
   logic                    tick;
   logic signed [CW-1:0]    isum_q;
   logic signed [CW-1:0]    pterm_q;
   logic signed [CW-1:0]    dsrc_prev_q;
   logic                    isign_q;
   logic signed [15:0]      sel_sp;
   logic signed [15:0]      sel_fb;
   logic signed [15:0]      sel_fb2;
   logic                    diff_en;
   logic                    conflict;
   logic signed [CW-1:0]    sp_eff;
   logic signed [CW-1:0]    fb_eff;
   logic signed [CW-1:0]    dev;
   logic signed [CW-1:0]    dsrc;
   logic signed [CW-1:0]    dterm;
   logic signed [CW-1:0]    pin;
   logic signed [CW-1:0]    isum_next;
   logic signed [CW-1:0]    iterm;
   logic signed [CW-1:0]    u;
   logic [CW-1:0]           quot;
   logic                    div_done;
   logic                    div_start;
   logic                    run;
   logic signed [CW-1:0]    gain_w;
   logic signed [CW-1:0]    dtime_w;

   generate
      if (TICK_CYCLES_P < CALC_W + 4) begin : g_chk
         $error("pfc_controller tick period too short");
      end
   endgenerate

   // Saturate a wide value to a signed 16-bit word
   function automatic logic signed [15:0] sat16(input logic signed [CW-1:0] v);
      if (v > CW'(32767))       return 16'sh7fff;
      else if (v < -CW'(32768)) return 16'sh8000;
      else                      return v[15:0];
   endfunction

   // Clamp an unsigned tuning value to its maximum
   function automatic logic [11:0] clamp12(input logic [11:0] v, input logic [11:0] lim);
      return (v > lim) ? lim : v;
   endfunction

   // Sign-extend a 16-bit word to the datapath width
   function automatic logic signed [CW-1:0] ext(input logic signed [15:0] v);
      return CW'(v);
   endfunction

   // Documented register port: setpoint word and serial select word
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sp_word_q  <= REG_SETPOINT_RESET;
         sel_word_q <= REG_SERIAL_SEL_RESET;
      end else if (reg_wr_in) begin
         if (reg_addr_in == REG_SETPOINT_IDX) begin
            sp_word_q <= reg_wdata_in;
         end
         if (reg_addr_in == REG_SERIAL_SEL_IDX) begin
            sel_word_q <= reg_wdata_in;
         end
      end
   end

   // Registered read, unmapped addresses read zero
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         reg_rdata_out <= 16'h0000;
      end else begin
         case (reg_addr_in)
            REG_SETPOINT_IDX:   reg_rdata_out <= sp_word_q;
            REG_SERIAL_SEL_IDX: reg_rdata_out <= sel_word_q;
            default:            reg_rdata_out <= 16'h0000;
         endcase
      end
   end

   // Tuning values, loaded by strobe; out-of-range mode is ignored
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         tune_q.mode  <= MODE_OFF;
         tune_q.gain  <= GAIN_RESET;
         tune_q.itime <= ITIME_RESET;
         tune_q.dtime <= DTIME_RESET;
      end else if (tune_load_in) begin
         if (tune_in.mode <= MODE_TRIM_FB) begin
            tune_q.mode <= tune_in.mode;
         end
         tune_q.gain  <= clamp12(tune_in.gain, GAIN_MAX);
         tune_q.itime <= clamp12(tune_in.itime, ITIME_MAX);
         tune_q.dtime <= (tune_in.dtime > DTIME_MAX) ? DTIME_MAX : tune_in.dtime;
      end
   end

   assign tune_out = tune_q;

   // Sample tick divider
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         tick_cnt_q <= '0;
      end else if (tick_cnt_q == TW'(TICK_CYCLES_P - 1)) begin
         tick_cnt_q <= '0;
      end else begin
         tick_cnt_q <= tick_cnt_q + 1'b1;
      end
   end

   assign tick = (tick_cnt_q == TW'(TICK_CYCLES_P - 1));
   assign run  = (tune_q.mode != MODE_OFF);

   pfc_source_select u_sel (
      .route_in         (route_in),
      .inputs_in        (inputs_in),
      .serial_sp_en_in  (sel_word_q[SERIAL_SEL_SP_BIT]),
      .serial_sp_in     (sp_word_q),
      .setpoint_out     (sel_sp),
      .feedback_out     (sel_fb),
      .feedback_two_out (sel_fb2),
      .diff_fb_en_out   (diff_en),
      .conflict_out     (conflict)
   );

   // Setpoint, feedback and deviation
   always_comb begin
      if (tune_q.mode == MODE_DIRECT_IN || tune_q.mode == MODE_DIRECT_FB) begin
         sp_eff = ext(freq_ref_in);
      end else begin
         sp_eff = ext(sel_sp);
      end
      fb_eff = diff_en ? ext(sel_fb) - ext(sel_fb2) : ext(sel_fb);
      dev    = sp_eff - fb_eff;
   end

   // Derivative source per mode, signed so it brakes like the deviation
   always_comb begin
      case (tune_q.mode)
         MODE_DIRECT_IN: dsrc = dev;
         MODE_DIRECT_FB: dsrc = -fb_eff;
         MODE_TRIM_DIFF: dsrc = -(fb_eff - sp_eff);
         MODE_TRIM_FB:   dsrc = -fb_eff;
         default:        dsrc = '0;
      endcase
   end

   // Tuning values widened as non-negative signed operands, so products and the gain division stay signed
   assign gain_w  = $signed({{(CW-12){1'b0}}, tune_q.gain});
   assign dtime_w = $signed({{(CW-10){1'b0}}, tune_q.dtime});

   // Slope times derivative time, added to the controller input
   assign dterm = (dsrc - dsrc_prev_q) * dtime_w * CW'(DTIME_TICKS);
   assign pin   = dev + dterm;

   // Integral accumulates the deviation once per tick
   assign isum_next = isum_q + dev;

   // Control sequence: sample, divide the integral, form the output
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: if (tick && run) state_q <= (tune_q.itime != 12'h000) ? ST_DIV : ST_OUT;
            ST_DIV:  if (div_done) state_q <= ST_OUT;
            ST_OUT:  state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   assign div_start = (state_q == ST_IDLE) && tick && run && (tune_q.itime != 12'h000);

   // Integral sum, cleared when off or integral disabled
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         isum_q <= '0;
      end else if (!run || tune_q.itime == 12'h000) begin
         isum_q <= '0;
      end else if (state_q == ST_IDLE && tick) begin
         isum_q <= isum_next;
      end
   end

   // Proportional term and derivative history latched at the tick
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pterm_q     <= '0;
         dsrc_prev_q <= '0;
         isign_q     <= 1'b0;
      end else if (state_q == ST_IDLE && tick) begin
         pterm_q     <= (pin * gain_w) / CW'(GAIN_SCALE);
         dsrc_prev_q <= run ? dsrc : '0;
         isign_q     <= isum_next[CW-1];
      end
   end

   pfc_divider #(
      .W (CW)
   ) u_div (
      .mclk_in      (mclk_in),
      .arst_n_in    (arst_n_in),
      .start_in     (div_start),
      .dividend_in  (isum_next[CW-1] ? -isum_next : isum_next),
      .divisor_in   (CW'(tune_q.itime) * CW'(ITIME_TICKS)),
      .quotient_out (quot),
      .done_out     (div_done)
   );

   // Integral term: sum over integral time, zero when disabled
   always_comb begin
      if (tune_q.itime == 12'h000) begin
         iterm = '0;
      end else begin
         iterm = isign_q ? -$signed(quot) : $signed(quot);
      end
      u = pterm_q + iterm;
   end

   // Frequency command: replace or trim the reference
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         freq_cmd_out <= 16'sh0000;
      end else if (!run) begin
         freq_cmd_out <= freq_ref_in;
      end else if (state_q == ST_OUT) begin
         case (tune_q.mode)
            MODE_DIRECT_IN, MODE_DIRECT_FB: freq_cmd_out <= sat16(u);
            MODE_TRIM_DIFF, MODE_TRIM_FB:   freq_cmd_out <= sat16(ext(freq_ref_in) + u);
            default:                        freq_cmd_out <= freq_ref_in;
         endcase
      end
   end

   // Status outputs
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         feedback_monitor_out       <= 16'sh0000;
         setting_conflict_alarm_out <= 1'b0;
         pid_active_out             <= 1'b0;
      end else begin
         feedback_monitor_out       <= sat16(fb_eff);
         setting_conflict_alarm_out <= conflict;
         pid_active_out             <= run;
      end
   end
endmodule
`default_nettype wire

// >>> verif/pfc_ctl_sva.sv
`timescale 1ns/10ps
`default_nettype none
module pfc_ctl_sva
   import pfc_pkg::*;
(
   input wire logic               mclk_in,
   input wire logic               arst_n_in,
   input wire logic               reg_wr_in,
   input wire logic [3:0]         reg_addr_in,
   input wire logic [15:0]        reg_wdata_in,
   input wire logic [15:0]        reg_rdata_out,
   input wire logic               tune_load_in,
   input wire pfc_pkg::pfc_tune_t tune_in,
   input wire pfc_pkg::pfc_tune_t tune_out,
   input wire pfc_pkg::pfc_route_t route_in,
   input wire logic signed [15:0] freq_ref_in,
   input wire logic signed [15:0] freq_cmd_out,
   input wire logic               setting_conflict_alarm_out,
   input wire logic               pid_active_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!arst_n_in);
   // Setpoint word written, then read back on the next cycle
   sequence s_wr6; reg_wr_in && reg_addr_in == REG_SETPOINT_IDX; endsequence
   sequence s_rd6; !reg_wr_in && reg_addr_in == REG_SETPOINT_IDX; endsequence
   property p_rdback; s_wr6 ##1 s_rd6 |=> reg_rdata_out == $past(reg_wdata_in, 2); endproperty
   a_rdback: assert property (p_rdback) else $error("setpoint word read back wrong");
   property p_unmap;
      reg_addr_in != REG_SETPOINT_IDX && reg_addr_in != REG_SERIAL_SEL_IDX |=> reg_rdata_out == 16'h0000;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_gain; tune_load_in && tune_in.gain > GAIN_MAX |=> tune_out.gain == GAIN_MAX; endproperty
   a_gain: assert property (p_gain) else $error("gain not clamped");
   property p_itime; tune_load_in && tune_in.itime <= ITIME_MAX |=> tune_out.itime == $past(tune_in.itime); endproperty
   a_itime: assert property (p_itime) else $error("integral time not loaded");
   property p_mode; tune_load_in && tune_in.mode > MODE_TRIM_FB |=> $stable(tune_out.mode); endproperty
   a_mode: assert property (p_mode) else $error("illegal mode accepted");
   property p_hold; !tune_load_in |=> $stable(tune_out); endproperty
   a_hold: assert property (p_hold) else $error("tuning changed without load");
   property p_follow;
      $past(arst_n_in) && tune_out.mode == MODE_OFF && $past(tune_out.mode) == MODE_OFF
         |-> freq_cmd_out == $past(freq_ref_in);
   endproperty
   a_follow: assert property (p_follow) else $error("command not following reference");
   property p_conf;
      route_in.ain1_func == AIN_FUNC_SETPOINT && route_in.ain2_func == AIN_FUNC_SETPOINT
         |=> setting_conflict_alarm_out;
   endproperty
   a_conf: assert property (p_conf) else $error("duplicate setpoint not flagged");
   property p_act; (tune_out.mode != MODE_OFF) [*2] |-> pid_active_out; endproperty
   a_act: assert property (p_act) else $error("controller not active");
   property p_idle; (tune_out.mode == MODE_OFF) [*2] |-> !pid_active_out; endproperty
   a_idle: assert property (p_idle) else $error("controller active in mode 0");
endmodule
bind pfc_controller pfc_ctl_sva u_sva (.mclk_in, .arst_n_in, .reg_wr_in, .reg_addr_in, .reg_wdata_in,
   .reg_rdata_out, .tune_load_in, .tune_in, .tune_out, .route_in, .freq_ref_in, .freq_cmd_out,
   .setting_conflict_alarm_out, .pid_active_out);
`default_nettype wire

// >>> verif/pfc_sensor_model.sv
`timescale 1ns/10ps
`default_nettype none
module pfc_sensor_model
   import pfc_pkg::*;
(
   input  wire logic                 mclk_in,
   input  wire pfc_pkg::pfc_inputs_t set_in,
   output var  pfc_pkg::pfc_inputs_t val_out
);
   // Sensor and parameter levels settle one clock after being set
   always @(posedge mclk_in) begin
      val_out <= #1 set_in;
   end
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import pfc_pkg::*;
   logic               mclk = 1'b0;
   logic               arst_n = 1'b0;
   logic               wr = 1'b0;
   logic               ld = 1'b0;
   logic [3:0]         addr = 4'h0;
   logic [15:0]        wdata = 16'h0000;
   logic [15:0]        rdata;
   logic [15:0]        lfsr = 16'h001c;
   logic signed [15:0] fref = 16'sh0000;
   logic signed [15:0] cmd;
   logic signed [15:0] mon;
   logic               alarm;
   logic               act;
   pfc_tune_t          tune = '0;
   pfc_tune_t          tout;
   pfc_route_t         route = '0;
   pfc_inputs_t        ins_set = '0;
   pfc_inputs_t        ins;
   logic [13:0]        rt [6] = '{14'h1600, 14'h18c0, 14'h1602, 14'h2d60, 14'h0004, 14'h0001};
   int                 n_mismatch = 0;
   int                 comparisons = 0;
   int                 q [$];
   int                 g;
   int                 fb;
   int                 fin;
   // Clock
   initial forever #5 mclk = ~mclk;
   pfc_sensor_model u_sens (.mclk_in(mclk), .set_in(ins_set), .val_out(ins));
   pfc_controller #(.TICK_CYCLES_P(64)) uut (.mclk_in(mclk), .arst_n_in(arst_n), .reg_wr_in(wr),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .tune_load_in(ld), .tune_in(tune),
      .route_in(route), .inputs_in(ins), .freq_ref_in(fref), .freq_cmd_out(cmd), .feedback_monitor_out(mon),
      .setting_conflict_alarm_out(alarm), .pid_active_out(act), .tune_out(tout));
   function automatic logic [15:0] lfsr_f(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic wreg(input logic [3:0] a, input logic [15:0] d);
      wr = 1'b1;
      addr = a;
      wdata = d;
      cyc(1);
      wr = 1'b0;
      cyc(1);
   endtask
   task automatic rreg(input logic [3:0] a, input logic [15:0] e);
      addr = a;
      cyc(1);
      chk("rdata", rdata, e);
   endtask
   task automatic tload(input int m, input int gn, input int it, input int d);
      tune = '{3'(m), 12'(gn), 12'(it), 10'(d)};
      ld = 1'b1;
      cyc(1);
      ld = 0;
   endtask
   // Collect every new command value within a window
   task automatic watch(input int n);
      logic signed [15:0] p;
      p = cmd;
      q.delete();
      repeat (n) begin
         cyc(1);
         if (cmd !== p) begin
            q.push_back(int'(cmd));
            p = cmd;
         end
      end
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Hang guard
   initial begin
      repeat (20000) @(posedge mclk);
      n_mismatch++;
      wrap_up();
   end
   // Main sequence
   initial begin
      cyc(10);
      arst_n = 1'b1;
      chk("gain", tout.gain, GAIN_RESET);
      chk("itime", tout.itime, ITIME_RESET);
      chk("mode", tout.mode, MODE_OFF);
      rreg(REG_SETPOINT_IDX, REG_SETPOINT_RESET);
      wreg(REG_SETPOINT_IDX, 16'h1234);
      wreg(REG_SERIAL_SEL_IDX, 16'h0002);
      wreg(4'h3, 16'hffff);
      rreg(REG_SETPOINT_IDX, 16'h1234);
      rreg(REG_SERIAL_SEL_IDX, 16'h0002);
      rreg(4'h3, 16'h0000);
      tload(3'h7, 12'hfff, 12'hfff, 10'h3ff);
      chk("clamp", tout, {MODE_OFF, GAIN_MAX, ITIME_MAX, DTIME_MAX});
      for (int i = 0; i < 6; i++) begin
         route = rt[i];
         cyc(2);
         chk("alarm", alarm, i != 0);
      end
      wreg(REG_SERIAL_SEL_IDX, 16'h0000);
      route = 14'h1760;
      ins_set.ain1 = 500;
      ins_set.ain2 = 120;
      cyc(3);
      chk("mon_diff", mon, 380);
      route = 14'h0002;
      ins_set.pulse = 77;
      cyc(3);
      chk("mon_pulse", mon, 77);
      fref = 1234;
      cyc(2);
      chk("follow", cmd, 1234);
      chk("act_off", act, 1'b0);
      route = 14'h1600;
      fref = 1000;
      for (int k = 0; k < 3; k++) begin
         lfsr = lfsr_f(lfsr);
         g = lfsr % 2501;
         lfsr = lfsr_f(lfsr);
         fb = lfsr & 16'h03ff;
         ins_set.ain1 = 16'(fb);
         tload(MODE_DIRECT_IN, g, 0, 0);
         cyc(200);
         chk("p_out", cmd, (1000 - fb) * g / 100);
         chk("act_on", act, 1'b1);
      end
      route = 14'h1601;
      ins_set.ain1 = 200;
      for (int m = 1; m < 5; m++) begin
         fref = 400;
         ins_set.param_sp = 600;
         tload(m, 100, 0, 1);
         cyc(250);
         if (m < 3) fref = 500;
         else ins_set.param_sp = 700;
         watch(260);
         fin = (m < 3) ? 300 : 900;
         chk("d_count", q.size(), (m % 2) ? 2 : 1);
         chk("d_final", q[q.size() - 1], fin);
         if (m % 2) chk("d_kick", q[0], fin + 1000);
      end
      route = 14'h1600;
      fref = 500;
      tload(MODE_OFF, 0, 0, 0);
      cyc(5);
      tload(MODE_DIRECT_IN, 0, 1, 0);
      watch(520);
      chk("i_count", q.size() >= 6, 1'b1);
      foreach (q[i]) chk("i_out", q[i], 3 * (i + 1));
      tload(MODE_DIRECT_IN, 0, 0, 0);
      cyc(200);
      chk("i_off", cmd, 0);
      wrap_up();
   end
endmodule
`default_nettype wire
